// File: hw/mbs_pkg.sv
// Purpose: Shared constants and carrier types for the submode selector
// Assumes: Parameter numbers are indices of a 16-bit parameter port
// Notes: Task mode table entries are 32 bits wide
package mbs_pkg;
    // ---------------------------------------------------------------
    // Parameter numbers
    // ---------------------------------------------------------------
    localparam logic [15:0] MBS_PN_BLOCK_SELECT = 16'h2532;
    localparam logic [15:0] MBS_PN_ACTIVE_BLOCK = 16'h2533;
    localparam logic [15:0] MBS_PN_DI_ACCEL = 16'h2536;
    localparam logic [15:0] MBS_PN_DI_DECEL = 16'h2537;
    localparam logic [15:0] MBS_PN_DI_MODE = 16'h2538;
    localparam logic [15:0] MBS_PN_TASK_MODE = 16'h2610;
    // ---------------------------------------------------------------
    // Field layout
    // ---------------------------------------------------------------
    localparam int MBS_REC_W = 10;
    localparam int MBS_IDX_W = 6;
    localparam int MBS_NUM_REC = 64;
    localparam int MBS_SUB_BIT = 15;
    localparam int MBS_ABS_BIT = 0;
    localparam int MBS_CW1_TERM_BIT = 4;
    localparam int MBS_CW2_ABS_BIT = 0;
    localparam int MBS_CW2_OVR_BIT = 10;
    localparam logic [15:0] MBS_SEL_MASK = 16'h83FF;
    localparam logic [15:0] MBS_MODE_MASK = 16'h0001;
    localparam logic [31:0] MBS_TASK_MASK = 32'h0000_0001;
    localparam logic [15:0] MBS_RESET16 = 16'h0000;
    localparam logic [15:0] MBS_FULL_SCALE = 16'hFFFF;
    localparam logic [15:0] MBS_MUL_ONE = 16'h0001;
    // ---------------------------------------------------------------
    // Range limit designation
    // ---------------------------------------------------------------
    localparam logic [1:0] MBS_RANGE_OFF = 2'h0;
    localparam logic [1:0] MBS_RANGE_SHORT = 2'h1;
    localparam logic [1:0] MBS_RANGE_POS = 2'h2;
    localparam logic [1:0] MBS_RANGE_NEG = 2'h3;

    typedef enum logic [2:0] {
        MBS_ST_ABS = 3'h1,
        MBS_ST_REL = 3'h2,
        MBS_ST_OFS = 3'h4
    } mbs_target_t;

    typedef enum logic [2:0] {
        MBS_SM_PROG = 3'h1,
        MBS_SM_WAIT = 3'h2,
        MBS_SM_DI = 3'h4
    } mbs_sub_t;

    typedef struct packed {
        logic wr;
        logic [15:0] pnum;
        logic [5:0] sub;
        logic [31:0] data;
    } mbs_param_t;

    typedef struct packed {
        logic [15:0] target;
        logic [31:0] velocity;
    } mbs_direct_t;

    typedef struct packed {
        logic direct;
        logic [5:0] start_rec;
        mbs_target_t kind;
        logic [1:0] route;
        logic [31:0] velocity;
        logic [15:0] target;
        logic [31:0] accel;
        logic [31:0] decel;
    } mbs_record_t;
endpackage

// File: hw/mbs_ramp_scale.sv
// Purpose: Scales a normalized ramp against its maximum
// Assumes: Full scale code means one hundred percent
// Notes: Result rounds down
`timescale 1ns/100ps
`default_nettype none
module mbs_ramp_scale
    import mbs_pkg::*;
(
    input wire logic [15:0] norm_i,
    input wire logic [31:0] max_i,
    output logic [31:0] ramp_o
);
    logic [47:0] prod;
    always_comb begin
        prod = max_i * norm_i;
        // Full scale gives exactly the maximum, not 65535/65536 of it
        if (norm_i == MBS_FULL_SCALE) begin
            ramp_o = max_i;
        end else begin
            ramp_o = prod[47:16];
        end
    end
endmodule
`default_nettype wire

// File: hw/mbs_target_kind.sv
// Purpose: Decodes how a target position is to be read
// Assumes: Range designation valid 0 to 3
// Notes: Combinational
`timescale 1ns/100ps
`default_nettype none
module mbs_target_kind
    import mbs_pkg::*;
(
    input wire logic abs_i,
    input wire logic [1:0] range_i,
    output mbs_target_t kind_o
);
    always_comb begin
        if (abs_i) begin
            kind_o = MBS_ST_ABS;
        end else if (range_i == MBS_RANGE_OFF) begin
            kind_o = MBS_ST_REL;
        end else begin
            kind_o = MBS_ST_OFS;
        end
    end
endmodule
`default_nettype wire

// File: hw/mbs_submode.sv
// Purpose: Submode select, active record and direct input parameters
// Assumes: Parameter port writes are single-cycle strobes
// Notes: Reads answer one cycle later from a registered copy of the next state
//
// Contract
// - Selection bits 0-9 hold record number
// - Record number used only in program submode
// - Bit 15 set waits for program end
// - Bit 15 clear aborts direct command
// - Status bits 0-9 show executing record
// - Status record reads zero when idle
// - Status bit 15 selects direct inputs
// - Program start record from bits 0-5
// - Acceleration FFFFh equals maximum acceleration
// - Deceleration FFFFh equals maximum deceleration
// - Range off: mode bit absolute/relative
// - Range on: mode bit absolute/offset
// - Task bit 0 absolute or relative
// - Range on: task bit absolute/offset
// - Override uses control word two bit
// - Range designation encodes four modes
`timescale 1ns/100ps
`default_nettype none
module mbs_submode
    import mbs_pkg::*;
#(
    parameter int NUM_REC = MBS_NUM_REC
)(
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire mbs_param_t param_i,
    input wire mbs_direct_t direct_i,
    input wire logic [15:0] control_word_one_i,
    input wire logic [15:0] control_word_two_i,
    input wire logic [1:0] range_designation_i,
    input wire logic program_running_i,
    input wire logic [5:0] executing_record_i,
    input wire logic direct_busy_i,
    input wire logic [31:0] max_accel_i,
    input wire logic [31:0] max_decel_i,
    output logic [31:0] rd_data_o,
    output logic direct_reject_o,
    output logic stop_interp_o,
    output mbs_record_t record_o
);
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    typedef struct packed {
        logic [15:0] sel;
        logic [15:0] accel;
        logic [15:0] decel;
        logic [15:0] mode;
        mbs_sub_t sub;
        logic [15:0] active;
        logic [31:0] rd;
        logic reject;
        logic stop;
        mbs_record_t rec;
    } mbs_state_t;

    mbs_state_t st_reg;
    mbs_state_t st_next;
    logic [NUM_REC-1:0] task_abs_reg;
    logic [31:0] acc_scaled;
    logic [31:0] dec_scaled;
    mbs_target_t di_kind;
    mbs_target_t rec_kind;
    logic di_abs;
    logic want_direct;
    logic term_req;

    function automatic logic hit(input mbs_param_t p,
                                 input logic [15:0] pn);
        hit = p.wr && (p.pnum == pn);
    endfunction

    // ---------------------------------------------------------------
    // Ramp scaling and target kind
    // ---------------------------------------------------------------
    mbs_ramp_scale u_acc (
        .norm_i(st_reg.accel),
        .max_i(max_accel_i),
        .ramp_o(acc_scaled)
    );
    mbs_ramp_scale u_dec (
        .norm_i(st_reg.decel),
        .max_i(max_decel_i),
        .ramp_o(dec_scaled)
    );

    always_comb begin
        if (control_word_two_i[MBS_CW2_OVR_BIT]) begin
            di_abs = control_word_two_i[MBS_CW2_ABS_BIT];
        end else begin
            di_abs = st_reg.mode[MBS_ABS_BIT];
        end
    end

    mbs_target_kind u_di_kind (
        .abs_i(di_abs),
        .range_i(range_designation_i),
        .kind_o(di_kind)
    );
    mbs_target_kind u_rec_kind (
        .abs_i(task_abs_reg[st_reg.sel[MBS_IDX_W-1:0]]),
        .range_i(range_designation_i),
        .kind_o(rec_kind)
    );

    // ---------------------------------------------------------------
    // Task mode table: only bit 0 is kept
    // ---------------------------------------------------------------
    // One flop per record: every other bit of an entry is reserved,
    // so storing it would only cost area
    genvar g;
    generate
        for (g = 0; g < NUM_REC; g++) begin : g_task
            always_ff @(posedge core_clk_i) begin
                if (!rst_n_i) begin
                    task_abs_reg[g] <= 1'b0;
                end else if (hit(param_i, MBS_PN_TASK_MODE) &&
                             param_i.sub == 6'(g)) begin
                    task_abs_reg[g] <= param_i.data[MBS_ABS_BIT];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    assign term_req = control_word_one_i[MBS_CW1_TERM_BIT];

    always_comb begin
        st_next = st_reg;
        st_next.reject = 1'b0;
        st_next.stop = 1'b0;
        want_direct = st_reg.sel[MBS_SUB_BIT];
        if (hit(param_i, MBS_PN_BLOCK_SELECT)) begin
            st_next.sel = param_i.data[15:0] & MBS_SEL_MASK;
            want_direct = param_i.data[MBS_SUB_BIT];
        end
        if (hit(param_i, MBS_PN_DI_ACCEL)) begin
            st_next.accel = param_i.data[15:0];
        end
        if (hit(param_i, MBS_PN_DI_DECEL)) begin
            st_next.decel = param_i.data[15:0];
        end
        if (hit(param_i, MBS_PN_DI_MODE)) begin
            st_next.mode = param_i.data[15:0] & MBS_MODE_MASK;
        end
        case (st_reg.sub)
            MBS_SM_PROG: begin
                if (want_direct) begin
                    if (program_running_i && !term_req) begin
                        st_next.sub = MBS_SM_WAIT;
                    end else begin
                        st_next.sub = MBS_SM_DI;
                    end
                end
            end
            MBS_SM_WAIT: begin
                // Request withdrawn before the program ended: nothing to undo
                if (!want_direct) begin
                    st_next.sub = MBS_SM_PROG;
                end else if (!program_running_i || term_req) begin
                    st_next.sub = MBS_SM_DI;
                end
            end
            MBS_SM_DI: begin
                if (!want_direct) begin
                    st_next.sub = MBS_SM_PROG;
                    if (direct_busy_i) begin
                        st_next.reject = 1'b1;
                        st_next.stop = 1'b1;
                    end
                end
            end
            default: begin
                st_next.sub = MBS_SM_PROG;
            end
        endcase
        // Status word
        st_next.active = MBS_RESET16;
        if (st_next.sub == MBS_SM_DI) begin
            st_next.active[MBS_SUB_BIT] = 1'b1;
        end else if (program_running_i) begin
            st_next.active[MBS_IDX_W-1:0] = executing_record_i;
        end
        // Record inputs
        st_next.rec.direct = (st_next.sub == MBS_SM_DI);
        st_next.rec.route = range_designation_i;
        if (st_next.sub == MBS_SM_DI) begin
            st_next.rec.start_rec = '0;
            st_next.rec.kind = di_kind;
            st_next.rec.target = direct_i.target;
            st_next.rec.velocity = direct_i.velocity;
            st_next.rec.accel = acc_scaled;
            st_next.rec.decel = dec_scaled;
        end else begin
            st_next.rec.start_rec = st_reg.sel[MBS_IDX_W-1:0];
            st_next.rec.kind = rec_kind;
            st_next.rec.target = '0;
            st_next.rec.velocity = '0;
            st_next.rec.accel = '0;
            st_next.rec.decel = '0;
        end
        // Read port: built from the next state, so a read in the cycle
        // of a write already shows the written value, except for a task mode table entry
        st_next.rd = '0;
        case (param_i.pnum)
            MBS_PN_BLOCK_SELECT: st_next.rd = {16'h0000, st_next.sel};
            MBS_PN_ACTIVE_BLOCK: st_next.rd = {16'h0000, st_next.active};
            MBS_PN_DI_ACCEL: st_next.rd = {16'h0000, st_next.accel};
            MBS_PN_DI_DECEL: st_next.rd = {16'h0000, st_next.decel};
            MBS_PN_DI_MODE: st_next.rd = {16'h0000, st_next.mode};
            MBS_PN_TASK_MODE: begin
                st_next.rd = {31'h0000_0000, task_abs_reg[param_i.sub]};
            end
            default: st_next.rd = '0;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            st_reg <= '0;
            st_reg.sub <= MBS_SM_PROG;
            st_reg.rec.kind <= MBS_ST_REL;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data_o = st_reg.rd;
    assign direct_reject_o = st_reg.reject;
    assign stop_interp_o = st_reg.stop;
    assign record_o = st_reg.rec;

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    sequence s_leave_busy;
        st_reg.sub == MBS_SM_DI && !want_direct && direct_busy_i;
    endsequence
    a_leave_reject: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) s_leave_busy |=> direct_reject_o && stop_interp_o)
        else $error("direct command not rejected");
    a_wait_prog: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (st_reg.sub == MBS_SM_PROG && want_direct &&
        program_running_i && !term_req) |=> st_reg.sub == MBS_SM_WAIT)
        else $error("switched while program runs");
    a_status_bit: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) st_reg.active[MBS_SUB_BIT] ==
        (st_reg.sub == MBS_SM_DI)) else $error("status bit wrong");
    a_idle_zero: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) !$past(program_running_i) |->
        st_reg.active[MBS_REC_W-1:0] == '0) else $error("idle record");
    a_rec_active: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (program_running_i && st_next.sub !=
        MBS_SM_DI) |=> st_reg.active[MBS_IDX_W-1:0] ==
        $past(executing_record_i)) else $error("active record wrong");
    a_sel_resv: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (st_reg.sel & ~MBS_SEL_MASK) == '0 &&
        st_reg.mode[15:1] == '0) else $error("reserved bits set");
    a_start_rec: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) !st_reg.rec.direct |->
        st_reg.rec.start_rec == $past(st_reg.sel[MBS_IDX_W-1:0]))
        else $error("start record wrong");
    a_override: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (st_next.sub == MBS_SM_DI &&
        control_word_two_i[MBS_CW2_OVR_BIT] &&
        control_word_two_i[MBS_CW2_ABS_BIT]) |=>
        st_reg.rec.kind == MBS_ST_ABS) else $error("override ignored");
    a_full_accel: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (st_reg.accel == MBS_FULL_SCALE) |->
        acc_scaled == max_accel_i) else $error("full scale wrong");

    // The switch is judged on the selection as it will stand this
    // cycle, so a write and its effect are seen together
    sequence s_want_prog;
        st_reg.sub == MBS_SM_PROG && want_direct;
    endsequence
    sequence s_want_wait;
        st_reg.sub == MBS_SM_WAIT && want_direct;
    endsequence
    sequence s_prog_done;
        !program_running_i || term_req;
    endsequence
    sequence s_prog_live;
        program_running_i && !term_req;
    endsequence
    a_switch_free: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) s_want_prog ##0 s_prog_done |=>
        st_reg.sub == MBS_SM_DI) else $error("switch held back");
    a_wait_release: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) s_want_wait ##0 s_prog_done |=>
        st_reg.sub == MBS_SM_DI) else $error("wait not released");
    a_wait_hold: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) s_want_wait ##0 s_prog_live |=>
        st_reg.sub == MBS_SM_WAIT) else $error("wait left early");
    a_reject_pulse: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) direct_reject_o |=> !direct_reject_o)
        else $error("reject longer than one cycle");
    a_leave_quiet: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (st_reg.sub == MBS_SM_DI && !want_direct &&
        !direct_busy_i) |=> !direct_reject_o && !stop_interp_o)
        else $error("idle leave rejected");
    a_di_start_zero: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) st_reg.rec.direct |->
        st_reg.rec.start_rec == '0) else $error("record used in direct");
    a_di_inputs: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) st_next.sub == MBS_SM_DI |=>
        st_reg.rec.target == $past(direct_i.target) &&
        st_reg.rec.velocity == $past(direct_i.velocity))
        else $error("direct inputs not taken");
    a_full_decel: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (st_reg.decel == MBS_FULL_SCALE) |->
        dec_scaled == max_decel_i) else $error("full scale decel wrong");
    a_route_copy: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) 1'b1 |=>
        st_reg.rec.route == $past(range_designation_i))
        else $error("route not passed on");
    a_di_rel: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (st_next.sub == MBS_SM_DI && !di_abs &&
        range_designation_i == MBS_RANGE_OFF) |=>
        st_reg.rec.kind == MBS_ST_REL) else $error("relative kind wrong");
    a_di_offset: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (st_next.sub == MBS_SM_DI && !di_abs &&
        range_designation_i != MBS_RANGE_OFF) |=>
        st_reg.rec.kind == MBS_ST_OFS) else $error("offset kind wrong");
    a_task_abs: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (st_next.sub != MBS_SM_DI &&
        task_abs_reg[st_reg.sel[MBS_IDX_W-1:0]]) |=>
        st_reg.rec.kind == MBS_ST_ABS) else $error("task absolute wrong");
    a_task_offset: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i) (st_next.sub != MBS_SM_DI &&
        !task_abs_reg[st_reg.sel[MBS_IDX_W-1:0]] &&
        range_designation_i != MBS_RANGE_OFF) |=>
        st_reg.rec.kind == MBS_ST_OFS) else $error("task offset wrong");
    a_active_resv: assert property (@(posedge core_clk_i)
        disable iff (!rst_n_i)
        st_reg.active[MBS_SUB_BIT-1:MBS_IDX_W] == '0)
        else $error("status reserved bits set");
endmodule
`default_nettype wire

// File: test/mbs_ctl_model.sv
// Purpose: Cyclic controller model writing and reading drive parameters
// Assumes: Answer is registered one cycle after the number is presented
// Notes: Data lines show the inverse of the last value once released
`timescale 1ns/100ps
`default_nettype none
module mbs_ctl_model
    import mbs_pkg::*;
(
    input wire logic core_clk_i,
    output mbs_param_t param_o,
    input wire logic [31:0] rd_data_i
);
    // ---------------------------------------------------------------
    // Parameter accesses
    // ---------------------------------------------------------------
    initial begin
        param_o = '0;
    end
    task automatic wr(input logic [15:0] pn, input logic [5:0] sb,
                      input logic [31:0] d);
        @(posedge core_clk_i);
        param_o <= '{wr: 1'b1, pnum: pn, sub: sb, data: d};
        @(posedge core_clk_i);
        param_o.wr <= 1'b0;
        param_o.data <= ~d;
    endtask
    // Number held for two edges so the registered answer matches it
    task automatic rd(input logic [15:0] pn, input logic [5:0] sb,
                      output logic [31:0] d);
        @(posedge core_clk_i);
        param_o <= '{wr: 1'b0, pnum: pn, sub: sb, data: ~param_o.data};
        @(posedge core_clk_i);
        @(posedge core_clk_i);
        d = rd_data_i;
    endtask
endmodule
`default_nettype wire

// File: test/mbs_submode_tb_top.sv
// Purpose: Self-checking bench for the submode selector
// Assumes: Fixed seed, controller model drives the parameter port
// Notes: Reject pulses are counted on falling edges
`timescale 1ns/100ps
`default_nettype none
module mbs_submode_tb_top;
    import mbs_pkg::*;
    logic clk, rst_n, run, busy, rej, stp;
    logic [15:0] cw1, cw2;
    logic [1:0] rng;
    logic [5:0] exrec;
    logic [31:0] maxa, maxd, rdd;
    mbs_param_t prm;
    mbs_direct_t dir;
    mbs_record_t rec;
    int err_count, num_checks, seed, rej_cnt, stp_cnt;
    mbs_submode dut_u (.core_clk_i(clk), .rst_n_i(rst_n), .param_i(prm),
        .direct_i(dir), .control_word_one_i(cw1),
        .control_word_two_i(cw2), .range_designation_i(rng),
        .program_running_i(run), .executing_record_i(exrec),
        .direct_busy_i(busy), .max_accel_i(maxa), .max_decel_i(maxd),
        .rd_data_o(rdd), .direct_reject_o(rej), .stop_interp_o(stp),
        .record_o(rec));
    mbs_ctl_model ctl_u (.core_clk_i(clk), .param_o(prm),
        .rd_data_i(rdd));
    // ---------------------------------------------------------------
    // Expectations and reporting
    // ---------------------------------------------------------------
    function automatic mbs_target_t kind_f(input logic ab,
                                           input logic [1:0] r);
        if (ab) return MBS_ST_ABS;
        return (r == MBS_RANGE_OFF) ? MBS_ST_REL : MBS_ST_OFS;
    endfunction
    function automatic logic [31:0] scale_f(input logic [15:0] n,
                                            input logic [31:0] m);
        logic [47:0] p;
        p = m * n;
        return (n == MBS_FULL_SCALE) ? m : p[47:16];
    endfunction
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic conclude();
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic rdchk(input logic [15:0] pn, input logic [5:0] sb,
                         input logic [31:0] e);
        logic [31:0] d;
        ctl_u.rd(pn, sb, d);
        chk("readback", e, d);
    endtask
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    initial begin
        #1_000_000;
        err_count++;
        conclude();
    end
    // Catches the pulse half a cycle after the rising edge launches it
    always @(negedge clk) begin
        if (rej === 1'b1) rej_cnt++;
        if (stp === 1'b1) stp_cnt++;
        if (rst_n === 1'b1) chk("stop", rej, stp);
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin : main
        logic [31:0] d, t, m, ac, dc;
        int j;
        seed = 88;
        {rst_n, run, busy, rng, exrec, cw1, cw2} = '0;
        {maxa, maxd, dir} = '0;
        err_count = 0;
        num_checks = 0;
        rej_cnt = 0;
        stp_cnt = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        chk("kind", 32'(MBS_ST_REL), 32'(rec.kind));
        rdchk(MBS_PN_DI_ACCEL, 6'h00, 32'h0000_0000);
        rdchk(MBS_PN_DI_DECEL, 6'h00, 32'h0000_0000);
        rdchk(MBS_PN_DI_MODE, 6'h00, 32'h0000_0000);
        rdchk(MBS_PN_TASK_MODE, 6'h3F, 32'h0000_0000);
        rdchk(MBS_PN_ACTIVE_BLOCK, 6'h00, 32'h0000_0000);
        rdchk(16'h1234, 6'h00, 32'h0000_0000);
        for (int i = 0; i < 12; i++) begin
            d = $random(seed);
            d[15] = 1'b0;
            t = $random(seed);
            run <= (i % 3) != 0;
            exrec <= 6'($random(seed));
            rng <= 2'($random(seed));
            ctl_u.wr(MBS_PN_BLOCK_SELECT, 6'h00, d);
            ctl_u.wr(MBS_PN_TASK_MODE, d[5:0], t);
            rdchk(MBS_PN_BLOCK_SELECT, 6'h00, d & MBS_SEL_MASK);
            rdchk(MBS_PN_TASK_MODE, d[5:0], t & MBS_TASK_MASK);
            rdchk(MBS_PN_ACTIVE_BLOCK, 6'h00,
                  run ? {26'h0, exrec} : 32'h0);
            chk("start", d[5:0], rec.start_rec);
            chk("route", rng, rec.route);
            chk("kind", kind_f(t[0], rng), rec.kind);
        end
        // Switch request held off by a running program
        for (j = 0; j < 2; j++) begin
            run <= 1'b1;
            ctl_u.wr(MBS_PN_BLOCK_SELECT, 6'h00, 32'h0000_8000);
            rdchk(MBS_PN_ACTIVE_BLOCK, 6'h00, {26'h0, exrec});
            if (j == 0) cw1[MBS_CW1_TERM_BIT] <= 1'b1;
            else run <= 1'b0;
            rdchk(MBS_PN_ACTIVE_BLOCK, 6'h00, 32'h0000_8000);
            cw1 <= 16'h0000;
            run <= 1'b0;
            for (int i = 0; i < 12 && j == 1; i++) begin
                m = $random(seed);
                ac = (i == 0) ? 32'h0000_FFFF : $random(seed);
                dc = (i == 1) ? 32'h0000_FFFF : $random(seed);
                maxa <= $random(seed);
                maxd <= $random(seed);
                dir <= 48'({$random(seed), $random(seed)});
                cw2 <= 16'($random(seed));
                rng <= 2'($random(seed));
                run <= 1'($random(seed));
                ctl_u.wr(MBS_PN_DI_MODE, 6'h00, m);
                ctl_u.wr(MBS_PN_DI_ACCEL, 6'h00, ac);
                ctl_u.wr(MBS_PN_DI_DECEL, 6'h00, dc);
                rdchk(MBS_PN_DI_MODE, 6'h00, m & MBS_MODE_MASK);
                rdchk(MBS_PN_DI_ACCEL, 6'h00, {16'h0, ac[15:0]});
                rdchk(MBS_PN_ACTIVE_BLOCK, 6'h00, 32'h8000);
                chk("direct", 32'h1, rec.direct);
                chk("target", dir.target, rec.target);
                chk("velocity", dir.velocity, rec.velocity);
                chk("accel", scale_f(ac[15:0], maxa), rec.accel);
                chk("decel", scale_f(dc[15:0], maxd), rec.decel);
                chk("start", 32'h0, rec.start_rec);
                chk("kind", kind_f(cw2[MBS_CW2_OVR_BIT] ? cw2[0] : m[0],
                    rng), rec.kind);
            end
            // Leaving the submode, with and without a live command
            busy <= (j == 1);
            run <= 1'b0;
            rej_cnt = 0;
            stp_cnt = 0;
            ctl_u.wr(MBS_PN_BLOCK_SELECT, 6'h00, 32'h0000_0000);
            repeat (4) @(posedge clk);
            busy <= 1'b0;
            chk("reject", j, rej_cnt);
            chk("stop", j, stp_cnt);
            chk("direct", 32'h0, rec.direct);
        end
        conclude();
    end
endmodule
`default_nettype wire
